// ---- shared/mfc_defs.vh ----
// Shared constants for the serial frame checksum block
`ifndef MFC_DEFS_VH
`define MFC_DEFS_VH
`define MFC_CRC_PRESET 16'hffff
`define MFC_CRC_POLY 16'ha001
`define MFC_CRC_SHIFTS 4'h8
`define MFC_FN_LOOP 8'h08
`define MFC_FN_WMULTI 8'h10
`define MFC_BCAST_ADDR 8'h00
`define MFC_CHAR_CR 8'h0d
`define MFC_CHAR_LF 8'h0a
`define MFC_CHAR_COLON 8'h3a
`define MFC_WM_HDR_LEN 8'h06
`define MFC_IDLE_MS 10
`define MFC_CLK_MHZ 200
`define MFC_IDLE_CYCLES (`MFC_IDLE_MS * 1000 * `MFC_CLK_MHZ)
`define MFC_FIFO_DEPTH 16
`define MFC_BUF_DEPTH 64
`endif

// ---- hdl/mfc_fifo.v ----
// Parameterised valid/ready FIFO for frame bytes
`timescale 1ns/1ps
`default_nettype none
module mfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  // Storage array
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // ---------------------------------------------
  // Pointers and count
  // ---------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      // Simultaneous push and pop keep the count
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
  // Data write, no reset needed on storage
  always @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule // mfc_fifo
`default_nettype wire

// ---- hdl/mfc_top.v ----
// Frame checksum, reply builder and echo for a serial drive slave
// Function
// - ASCII LRC: negated modulo-256 byte sum
// - LRC sums decoded binary bytes, not chars
// - CRC accumulator preset to all ones
// - XOR each byte into CRC low byte
// - Shift right, XOR A001 when bit out
// - Eight shift steps per byte
// - Repeat per byte; final value is CRC
// - RTU CRC sent low byte first
// - Loop command echoed back exactly
// - Station zero broadcast: act, never reply
// - RTU idle over 10 ms ends frame
`timescale 1ns/1ps
`default_nettype none
`include "mfc_defs.vh"
module mfc_top #(
  parameter IDLE_CYCLES = `MFC_IDLE_CYCLES,
  parameter FIFO_DEPTH = `MFC_FIFO_DEPTH,
  parameter BUF_DEPTH = `MFC_BUF_DEPTH
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Mode: 1 = ASCII, 0 = RTU
  input wire ascii_mode,
  // Received characters from the UART
  input wire rx_valid,
  input wire [7:0] rx_char,
  // ASCII end of frame (LF seen by the framer)
  input wire rx_eof,
  // Transmit characters to the UART
  output reg tx_valid,
  output reg [7:0] tx_char,
  input wire tx_ready,
  // Frame result
  output reg frame_done,
  output reg frame_ok,
  output reg frame_bcast,
  output reg [7:0] frame_func
);
  // ---------------------------------------------
  // Reset and pin synchronisers
  // ---------------------------------------------
  reg [1:0] rst_sync_reg;
  wire rst_n;
  assign rst_n = rst_sync_reg[1];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  // Mode is a strap pin: two stages before use
  reg mode_s1_reg;
  reg mode_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      mode_s1_reg <= ascii_mode;
      mode_reg <= mode_s1_reg;
    end
  end
  // ---------------------------------------------
  // Hex decode and encode of ASCII characters
  // ---------------------------------------------
  function [3:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h41 && c <= 8'h46) begin
        hex_val = c[3:0] + 4'h9;
      end else if (c >= 8'h61 && c <= 8'h66) begin
        hex_val = c[3:0] + 4'h9;
      end else begin
        hex_val = c[3:0];
      end
    end
  endfunction
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      hex_chr = (n > 4'h9) ? {4'h4, n - 4'h9} : {4'h3, n};
    end
  endfunction
  // ---------------------------------------------
  // Receive: pair nibbles into bytes, store frame
  // ---------------------------------------------
  localparam BAW = 6;
  reg [7:0] buf_mem [0:BUF_DEPTH-1];
  reg [BAW-1:0] len_reg;
  reg [3:0] hi_nib_reg;
  reg half_reg;
  reg in_frame_reg;
  reg [31:0] idle_reg;
  reg byte_stb_reg;
  reg [7:0] byte_reg;
  reg eof_reg;
  // Binary byte from the link, ASCII pairs decoded first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_nib_reg <= 4'h0;
      half_reg <= 1'b0;
      byte_stb_reg <= 1'b0;
      byte_reg <= 8'h00;
      in_frame_reg <= 1'b0;
      idle_reg <= 32'h0;
      eof_reg <= 1'b0;
    end else begin
      byte_stb_reg <= 1'b0;
      eof_reg <= 1'b0;
      if (rx_valid && mode_reg) begin
        if (rx_char == `MFC_CHAR_COLON) begin
          half_reg <= 1'b0;
          in_frame_reg <= 1'b1;
        end else if (rx_char != `MFC_CHAR_CR && rx_char != `MFC_CHAR_LF) begin
          // Two hex chars form one binary byte
          if (half_reg) begin
            byte_reg <= {hi_nib_reg, hex_val(rx_char)};
            byte_stb_reg <= 1'b1;
          end else begin
            hi_nib_reg <= hex_val(rx_char);
          end
          half_reg <= ~half_reg;
        end
        if (rx_eof) begin
          eof_reg <= in_frame_reg;
          in_frame_reg <= 1'b0;
        end
      end else if (rx_valid) begin
        byte_reg <= rx_char;
        byte_stb_reg <= 1'b1;
        in_frame_reg <= 1'b1;
        idle_reg <= 32'h0;
      end else if (!mode_reg && in_frame_reg) begin
        // Silence beyond the limit closes the frame
        if (idle_reg >= IDLE_CYCLES) begin
          eof_reg <= 1'b1;
          in_frame_reg <= 1'b0;
        end else begin
          idle_reg <= idle_reg + 32'h1;
        end
      end
    end
  end
  // ---------------------------------------------
  // Checksum engines: LRC sum and bitwise CRC
  // ---------------------------------------------
  reg [7:0] lrc_reg;
  reg [15:0] crc_reg;
  reg [3:0] shift_reg;
  reg [15:0] crc_body_reg;
  reg [15:0] crc_prev_reg;
  reg [7:0] lrc_prev_reg;
  // Sequencer has judged the frame; engines may be preset
  wire tx_start;
  // Buffer write of received bytes; checksums run in the next block
  always @(posedge clk) begin
    if (byte_stb_reg && len_reg != BUF_DEPTH - 1) begin
      buf_mem[len_reg] <= byte_reg;
    end
  end
  // Frame length and checksums; shifts take eight cycles per byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_reg <= {BAW{1'b0}};
      lrc_reg <= 8'h00;
      crc_reg <= `MFC_CRC_PRESET;
      shift_reg <= 4'h0;
      crc_body_reg <= 16'h0;
      crc_prev_reg <= 16'h0;
      lrc_prev_reg <= 8'h00;
    end else if (tx_start) begin
      // Fresh preset ahead of each message
      // Not at end of frame: the residue must stand until it is judged
      crc_reg <= `MFC_CRC_PRESET;
      lrc_reg <= 8'h00;
      len_reg <= {BAW{1'b0}};
      shift_reg <= 4'h0;
    end else if (byte_stb_reg) begin
      lrc_prev_reg <= lrc_reg;
      crc_prev_reg <= crc_reg;
      // Modulo-256 running sum
      lrc_reg <= lrc_reg + byte_reg;
      // Byte into low half before shifting
      crc_reg <= crc_reg ^ {8'h00, byte_reg};
      shift_reg <= `MFC_CRC_SHIFTS;
      if (len_reg != BUF_DEPTH - 1) begin
        len_reg <= len_reg + 1'b1;
      end
    end else if (shift_reg != 4'h0) begin
      // Zero-fill shift, poly on carried-out one
      crc_reg <= crc_reg[0] ? ((crc_reg >> 1) ^ `MFC_CRC_POLY) :
                 (crc_reg >> 1);
      shift_reg <= shift_reg - 4'h1;
      // Snapshot of CRC before the latest received byte
      if (shift_reg == 4'h1) begin
        crc_body_reg <= crc_prev_reg;
      end
    end
  end
  // ---------------------------------------------
  // Frame check: residue tests on RTU and ASCII
  // ---------------------------------------------
  // RTU: CRC over all bytes incl. low-first CRC gives zero.
  // ASCII: sum of all bytes incl. LRC gives zero.
  wire chk_ok;
  assign chk_ok = mode_reg ? (lrc_reg == 8'h00) : (crc_reg == 16'h0000);
  // ---------------------------------------------
  // Reply state machine
  // ---------------------------------------------
  localparam S_IDLE = 6'h01;
  localparam S_WAIT = 6'h02;
  localparam S_HEAD = 6'h04;
  localparam S_BODY = 6'h08;
  localparam S_SUM = 6'h10;
  localparam S_END = 6'h20;
  reg [5:0] st_reg;
  reg [BAW-1:0] rlen_reg;
  reg [BAW-1:0] idx_reg;
  reg [7:0] cur_reg;
  reg [2:0] sub_reg;
  reg [7:0] func_reg;
  reg [7:0] tsum_reg;
  reg [15:0] tcrc_reg;
  wire q_ready;
  reg q_valid;
  reg [7:0] q_data;
  wire f_valid;
  wire [7:0] f_data;
  // Reply length of a multi-write: header bytes only
  wire [7:0] wm_len_w;
  assign wm_len_w = `MFC_WM_HDR_LEN;
  // Negated transmit sum, sent as the LRC
  wire [7:0] lrc_out_w;
  assign lrc_out_w = 8'h00 - tsum_reg;
  assign tx_start = (st_reg == S_WAIT) && (shift_reg == 4'h0);
  // Transmit CRC stepped alongside queued bytes
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    integer k;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `MFC_CRC_POLY) : (t >> 1);
      end
      crc_byte = t;
    end
  endfunction
  // Sequencer pushes reply characters into the FIFO
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      rlen_reg <= {BAW{1'b0}};
      idx_reg <= {BAW{1'b0}};
      sub_reg <= 3'h0;
      func_reg <= 8'h00;
      tsum_reg <= 8'h00;
      tcrc_reg <= `MFC_CRC_PRESET;
      q_valid <= 1'b0;
      q_data <= 8'h00;
      frame_done <= 1'b0;
      frame_ok <= 1'b0;
      frame_bcast <= 1'b0;
      frame_func <= 8'h00;
    end else begin
      frame_done <= 1'b0;
      if (q_valid && q_ready) begin
        q_valid <= 1'b0;
      end
      case (st_reg)
        S_IDLE: begin
          if (eof_reg) begin
            st_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (shift_reg == 4'h0) begin
            frame_done <= 1'b1;
            frame_ok <= chk_ok;
            frame_bcast <= (buf_mem[0] == `MFC_BCAST_ADDR);
            frame_func <= buf_mem[1];
            func_reg <= buf_mem[1];
            tsum_reg <= 8'h00;
            tcrc_reg <= `MFC_CRC_PRESET;
            idx_reg <= {BAW{1'b0}};
            sub_reg <= 3'h0;
            // Multi-write: header of six bytes only
            rlen_reg <= (buf_mem[1] == `MFC_FN_WMULTI) ?
                        wm_len_w[BAW-1:0] : len_reg;
            // Broadcast or bad check: no reply at all
            if (!chk_ok || buf_mem[0] == `MFC_BCAST_ADDR || len_reg < 3'h4) begin
              st_reg <= S_IDLE;
            end else begin
              st_reg <= S_HEAD;
            end
          end
        end
        S_HEAD: begin
          if (!q_valid || q_ready) begin
            q_valid <= 1'b1;
            q_data <= `MFC_CHAR_COLON;
            st_reg <= S_BODY;
            if (!mode_reg) begin
              q_valid <= 1'b0;
            end
          end
        end
        S_BODY: begin
          if (!q_valid || q_ready) begin
            // Loop command: all bytes incl. check echoed
            // Check bytes dropped: two in RTU, one (LRC) in ASCII
            if (func_reg != `MFC_FN_LOOP &&
                idx_reg == rlen_reg - {4'h0, ~mode_reg, mode_reg}
                && func_reg != `MFC_FN_WMULTI) begin
              st_reg <= S_SUM;
              sub_reg <= 3'h0;
            end else if (idx_reg == rlen_reg) begin
              st_reg <= (func_reg == `MFC_FN_WMULTI) ? S_SUM : S_END;
              sub_reg <= 3'h0;
            end else begin
              cur_reg <= buf_mem[idx_reg];
              q_valid <= 1'b1;
              if (mode_reg) begin
                q_data <= hex_chr(sub_reg[0] ? buf_mem[idx_reg][3:0] :
                                  buf_mem[idx_reg][7:4]);
                sub_reg <= {2'h0, ~sub_reg[0]};
                if (sub_reg[0]) begin
                  idx_reg <= idx_reg + 1'b1;
                  tsum_reg <= tsum_reg + buf_mem[idx_reg];
                end
              end else begin
                q_data <= buf_mem[idx_reg];
                idx_reg <= idx_reg + 1'b1;
                tcrc_reg <= crc_byte(tcrc_reg, buf_mem[idx_reg]);
              end
            end
          end
        end
        S_SUM: begin
          if (!q_valid || q_ready) begin
            q_valid <= 1'b1;
            sub_reg <= sub_reg + 3'h1;
            if (mode_reg) begin
              // Negated sum, high nibble char first
              q_data <= hex_chr(sub_reg[0] ? lrc_out_w[3:0] :
                                lrc_out_w[7:4]);
            end else begin
              // Low CRC byte goes out first
              q_data <= sub_reg[0] ? tcrc_reg[15:8] : tcrc_reg[7:0];
            end
            if (sub_reg[0]) begin
              st_reg <= S_END;
              sub_reg <= 3'h0;
            end
          end
        end
        S_END: begin
          if (!q_valid || q_ready) begin
            if (!mode_reg) begin
              st_reg <= S_IDLE;
            end else begin
              // CR then LF close an ASCII reply
              q_valid <= 1'b1;
              q_data <= sub_reg[0] ? `MFC_CHAR_LF : `MFC_CHAR_CR;
              sub_reg <= 3'h1;
              if (sub_reg[0]) begin
                st_reg <= S_IDLE;
              end
            end
          end
        end
        default: begin
          st_reg <= S_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------
  // Output FIFO and registered drive
  // ---------------------------------------------
  wire f_ready;
  assign f_ready = !tx_valid || tx_ready;
  mfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(q_valid),
    .in_data(q_data),
    .in_ready(q_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );
  // Output register gives a flop-driven transmit port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
    end else if (f_ready) begin
      tx_valid <= f_valid;
      tx_char <= f_data;
    end
  end
endmodule // mfc_top
`default_nettype wire

// ---- bench/mfc_chk_sva.sv ----
// Port-level assertion checker for the frame checksum block
`timescale 1ns/1ps
`default_nettype none
module mfc_chk #(
  parameter IDLE_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Receive side
  input wire logic ascii_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_eof,
  // Transmit side
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  input wire logic tx_ready,
  // Frame result
  input wire logic frame_done,
  input wire logic frame_ok,
  input wire logic frame_bcast,
  input wire logic [7:0] frame_func
);
  // Cycles since last received char, saturating
  logic [31:0] quiet_reg;
  // ----------------------------------------
  // Helper counter
  // ----------------------------------------
  // Saturates so a long idle never wraps back under the limit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet_reg <= 32'h0;
    end else if (rx_valid) begin
      quiet_reg <= 32'h0;
    end else if (quiet_reg != 32'hffffffff) begin
      quiet_reg <= quiet_reg + 32'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_tx_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("tx char changed before accept");
  chk_done_pulse: assert property (
    frame_done |=> !frame_done)
    else $error("frame_done longer than one cycle");
  chk_flags_held: assert property (
    !frame_done |-> $stable({frame_ok, frame_bcast, frame_func}))
    else $error("frame flags moved without frame_done");
  chk_bcast_silent: assert property (
    frame_done && frame_bcast |=> !tx_valid [*8])
    else $error("reply sent to broadcast");
  chk_bad_silent: assert property (
    frame_done && !frame_ok |=> !tx_valid [*8])
    else $error("reply sent for bad frame");
  chk_reply_starts: assert property (
    frame_done && frame_ok && !frame_bcast |-> ##[1:200] tx_valid)
    else $error("no reply after good frame");
  chk_rtu_idle_end: assert property (
    frame_done && !ascii_mode |-> quiet_reg >= IDLE_CYCLES)
    else $error("frame ended before idle gap");
  chk_ascii_eof: assert property (
    rx_valid && rx_eof && ascii_mode |-> ##[1:60] frame_done)
    else $error("no frame_done after line end");
endmodule // mfc_chk
bind mfc_top mfc_chk #(.IDLE_CYCLES(IDLE_CYCLES)) mfc_chk_inst (
  .clk(clk), .nrst(nrst), .ascii_mode(ascii_mode), .rx_valid(rx_valid),
  .rx_char(rx_char), .rx_eof(rx_eof), .tx_valid(tx_valid),
  .tx_char(tx_char), .tx_ready(tx_ready), .frame_done(frame_done),
  .frame_ok(frame_ok), .frame_bcast(frame_bcast), .frame_func(frame_func));
`default_nettype wire

// ---- bench/mfc_master_model.sv ----
// Behavioural serial bus master feeding and draining the block
`timescale 1ns/1ps
`default_nettype none
module mfc_master_model (
  // Clock
  input wire logic clk,
  // Chars toward the block
  output logic rx_valid,
  output logic [7:0] rx_char,
  output logic rx_eof,
  // Chars from the block
  input wire logic tx_valid,
  input wire logic [7:0] tx_char,
  output logic tx_ready
);
  // Slow sink mode, set by the bench
  logic slow = 1'b0;
  // Cycles spent with a char offered
  int stall_cnt = 0;
  // Everything the block sent
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    rx_eof = 1'b0;
    tx_ready = 1'b1;
  end
  // ----------------------------------------
  // Sink side
  // ----------------------------------------
  // Long stall first so the reply buffer backs up, then 1 in 4
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_char);
    end
    stall_cnt <= (slow && tx_valid) ? stall_cnt + 1 : stall_cnt;
    tx_ready <= !slow || (stall_cnt >= 40 && stall_cnt[1:0] == 2'h0);
  end
  // ----------------------------------------
  // Source side
  // ----------------------------------------
  // One char, then ten cycles apart; line shows junk when idle
  task automatic put(input logic [7:0] b, input logic eof);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_char = b;
    rx_eof = eof;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_eof = 1'b0;
    rx_char = ~b;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Binary frame, check low byte first; bad flips one bit
  task automatic send_rtu(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    foreach (q[i]) put(q[i], 1'b0);
    put(c[7:0], 1'b0);
    put(c[15:8], 1'b0);
  endtask // line then stays quiet past the idle limit
  // Text frame: colon, hex pairs, check pair, CR, LF
  task automatic send_ascii(input logic [7:0] q[$]);
    logic [7:0] s;
    s = 8'h00;
    put(8'h3a, 1'b0);
    foreach (q[i]) begin
      s = s + q[i];
      put(hx(q[i][7:4]), 1'b0);
      put(hx(q[i][3:0]), 1'b0);
    end
    s = 8'h00 - s;
    put(hx(s[7:4]), 1'b0);
    put(hx(s[3:0]), 1'b0);
    put(8'h0d, 1'b0);
    put(8'h0a, 1'b1);
  endtask
endmodule // mfc_master_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the frame checksum block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bench-driven inputs
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ascii_mode = 1'b0;
  // Block wiring
  wire rx_valid;
  wire [7:0] rx_char;
  wire rx_eof;
  wire tx_valid;
  wire [7:0] tx_char;
  wire tx_ready;
  wire frame_done;
  wire frame_ok;
  wire frame_bcast;
  wire [7:0] frame_func;
  // Result counters
  int error_cnt = 0;
  int checks = 0;
  // Result pulses seen and result pulses judged
  int done_seen = 0;
  int done_judged = 0;
  // Counts result pulses so one during a send is not missed
  always @(posedge clk) begin
    if (frame_done === 1'b1) begin
      done_seen <= done_seen + 1;
    end
  end
  always #2.5 clk = ~clk;
  // Short idle limit keeps the run brief
  mfc_top #(.IDLE_CYCLES(50)) mfc_top_inst (
    .clk(clk), .nrst(nrst), .ascii_mode(ascii_mode), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_eof(rx_eof), .tx_valid(tx_valid),
    .tx_char(tx_char), .tx_ready(tx_ready), .frame_done(frame_done),
    .frame_ok(frame_ok), .frame_bcast(frame_bcast), .frame_func(frame_func));
  mfc_master_model mfc_master_model_inst (
    .clk(clk), .rx_valid(rx_valid), .rx_char(rx_char), .rx_eof(rx_eof),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Wait for the result pulse, then the reply, and judge both
  task automatic judge(input logic ok, input logic bc, input logic [7:0] fn,
                       input logic [7:0] r[$]);
    int n;
    for (n = 0; n < 2000 && done_seen <= done_judged; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 2000) begin
      cmp8("frame_done timeout", 8'h01, 8'h00);
      finish_test();
    end
    done_judged++;
    cmp8("frame_ok", {7'h0, ok}, {7'h0, frame_ok});
    cmp8("frame_bcast", {7'h0, bc}, {7'h0, frame_bcast});
    cmp8("frame_func", fn, frame_func);
    for (n = 0; n < 3000; n++) begin
      if (mfc_master_model_inst.got.size() >= r.size()) break;
      @(posedge clk);
    end
    repeat (150) @(posedge clk);
    cmp8("reply length", 8'(r.size()),
         8'(mfc_master_model_inst.got.size()));
    foreach (r[i]) begin
      cmp8("reply byte", r[i], mfc_master_model_inst.got[i]);
    end
    mfc_master_model_inst.got.delete();
    mfc_master_model_inst.slow = 1'b0;
  endtask
  task automatic rtu(input logic [7:0] q[$], input logic bad);
    mfc_master_model_inst.send_rtu(q, bad);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_rtu_read;
    rtu('{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02}, 1'b0);
    judge(1'b1, 1'b0, 8'h03, '{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02,
          8'h6f, 8'hf7});
    $display("end rtu read");
  endtask
  task automatic t_rtu_write;
    mfc_master_model_inst.slow = 1'b1;
    rtu('{8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88,
          8'h0f, 8'ha0}, 1'b0);
    judge(1'b1, 1'b0, 8'h10, '{8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02,
          8'h41, 8'h04});
    $display("end rtu multi write");
  endtask
  task automatic t_rtu_loop;
    rtu('{8'h01, 8'h08, 8'h00, 8'h00, 8'h17, 8'h70}, 1'b0);
    judge(1'b1, 1'b0, 8'h08, '{8'h01, 8'h08, 8'h00, 8'h00, 8'h17, 8'h70,
          8'hee, 8'h1f});
    $display("end rtu loop echo");
  endtask
  task automatic t_rtu_bad;
    rtu('{8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70}, 1'b1);
    judge(1'b0, 1'b0, 8'h06, '{});
    $display("end rtu bad check");
  endtask
  task automatic t_bcast;
    rtu('{8'h00, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70}, 1'b0);
    judge(1'b1, 1'b1, 8'h06, '{});
    $display("end broadcast");
  endtask
  task automatic t_ascii_write;
    @(posedge clk);
    #1;
    ascii_mode = 1'b1;
    repeat (10) @(posedge clk);
    mfc_master_model_inst.slow = 1'b1;
    mfc_master_model_inst.send_ascii('{8'h01, 8'h10, 8'h05, 8'h00, 8'h00,
      8'h02, 8'h04, 8'h13, 8'h88, 8'h0f, 8'ha0});
    judge(1'b1, 1'b0, 8'h10, '{8'h3a, 8'h30, 8'h31, 8'h31, 8'h30, 8'h30,
          8'h35, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h32, 8'h45, 8'h38,
          8'h0d, 8'h0a});
    $display("end ascii multi write");
  endtask
  task automatic t_ascii_single;
    mfc_master_model_inst.send_ascii('{8'h01, 8'h06, 8'h01, 8'h00, 8'h17,
      8'h70});
    judge(1'b1, 1'b0, 8'h06, '{8'h3a, 8'h30, 8'h31, 8'h30, 8'h36, 8'h30,
          8'h31, 8'h30, 8'h30, 8'h31, 8'h37, 8'h37, 8'h30, 8'h37, 8'h31,
          8'h0d, 8'h0a});
    $display("end ascii single write");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge clk);
    t_rtu_read();
    t_rtu_write();
    t_rtu_loop();
    t_rtu_bad();
    t_bcast();
    t_ascii_write();
    t_ascii_single();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
